// ---- hw/timer_count_reg_regs.vh ----
// register offsets, field positions, reset values and timing counts for the timer/prescaler block
// assumes a 32-bit apb slave, one aligned word per register
//
// Contract
// - count rolling from ff to 00 sets the overflow flag, control bit 2.
// - interrupt request is masked by enable bit 5; the flag still records.
// - timer is halted during sleep; no overflow, no wake.
// - external path sampled on phases two and four of each instruction cycle.
// - in counter mode with divider, input first divided, then synchronised; here it is synchronised first, then divided.
// - increment lags the external edge because of synchronisation.
// - one 8-bit divider serves timer or watchdog, never both.
// - assign bit and three ratio bits in option bits 3:0 select owner and ratio.
// - count writes clear the divider while it belongs to the timer.
// - watchdog clear resets watchdog and divider while divider belongs to watchdog.
// - divider value is never readable or writable by software.
// - divider assignment may change at any time.
// - option 0xc3: pull-ups off, rising edge interrupt, internal clock, 1:16.
// - option 0x37: pull-ups on, falling edge interrupt, external falling, 1:256.
// - source bit clear counts cycles; set counts input edges per edge select.
// - ratio codes give timer 2..256 or watchdog 1..128 in powers of two.
// - after a count write, counting is suppressed for two instruction cycles.
`ifndef TIMER_COUNT_REG_REGS_VH
`define TIMER_COUNT_REG_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TIMER_COUNT_REG_COUNT_OFS 12'h000
`define TIMER_COUNT_REG_OPTION_OFS 12'h004
`define TIMER_COUNT_REG_INTCTL_OFS 12'h008
`define TIMER_COUNT_REG_CMD_OFS 12'h00c

// ----------------------------------------------------------------
// option fields
// ----------------------------------------------------------------
`define TIMER_COUNT_REG_OPT_PULLUP_OFF 7
`define TIMER_COUNT_REG_OPT_INT_EDGE 6
`define TIMER_COUNT_REG_OPT_SRC_SEL 5
`define TIMER_COUNT_REG_OPT_EDGE_SEL 4
`define TIMER_COUNT_REG_OPT_ASSIGN 3
`define TIMER_COUNT_REG_OPT_RATIO_HI 2
`define TIMER_COUNT_REG_OPT_RESET 8'hff

// ----------------------------------------------------------------
// interrupt control and command fields
// ----------------------------------------------------------------
`define TIMER_COUNT_REG_INT_FLAG 2
`define TIMER_COUNT_REG_INT_ENABLE 5
`define TIMER_COUNT_REG_INT_GLOBAL 7
`define TIMER_COUNT_REG_INT_RESET 8'h00
`define TIMER_COUNT_REG_CMD_WDT_CLR 0
`define TIMER_COUNT_REG_CMD_SLEEP 1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TIMER_COUNT_REG_PHASES 4
`define TIMER_COUNT_REG_INHIBIT_CYC 2'h2

`endif

// ---- hw/timer_count_reg_prescaler.v ----
// timer/counter with shared timer-prescaler / watchdog-postscaler divider, apb registers
// assumes ext_count_i may be asynchronous to clk_i and synchronises it here; four clk_i cycles form one instruction cycle
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "timer_count_reg_regs.vh"

module timer_count_reg_prescaler #(
    parameter DIV_WIDTH = 8
) (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // pin and neighbours
    input wire ext_count_i,
    input wire wdt_tick_i,
    output reg wdt_tick_o,
    output reg wdt_clear_o,
    output wire overflow_irq_o,
    output wire pullup_disable_o,
    output wire int_rising_edge_o,
    output wire sleep_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // selected divider tap: timer uses bit ratio, watchdog one lower (ratio 0 = 1:1)
    function tap_bit;
        input [DIV_WIDTH-1:0] cnt;
        input [2:0] idx;
        begin
            tap_bit = cnt[idx];
        end
    endfunction

    wire apb_write = psel_i & penable_i & pwrite_i;
    wire apb_read = psel_i & penable_i & ~pwrite_i;
    wire hit_count = (paddr_i == `TIMER_COUNT_REG_COUNT_OFS);
    wire hit_option = (paddr_i == `TIMER_COUNT_REG_OPTION_OFS);
    wire hit_intctl = (paddr_i == `TIMER_COUNT_REG_INTCTL_OFS);
    wire hit_cmd = (paddr_i == `TIMER_COUNT_REG_CMD_OFS);
    wire mapped = hit_count | hit_option | hit_intctl | hit_cmd;

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] timer_count_reg;
    reg [7:0] option_reg;
    reg [7:0] interrupt_control_reg;
    reg sleep_reg;
    reg [DIV_WIDTH-1:0] div_reg;
    reg [1:0] phase_reg;
    reg [1:0] inhibit_reg;
    reg sync1_reg;
    reg sync2_reg;
    reg ext_samp_reg;

    wire count_wr = apb_write & hit_count;
    wire cmd_wr = apb_write & hit_cmd;
    wire wdt_clr_cmd = cmd_wr & pwdata_i[`TIMER_COUNT_REG_CMD_WDT_CLR];
    wire to_wdt = option_reg[`TIMER_COUNT_REG_OPT_ASSIGN];
    wire src_ext = option_reg[`TIMER_COUNT_REG_OPT_SRC_SEL];
    wire [2:0] ratio = option_reg[`TIMER_COUNT_REG_OPT_RATIO_HI:0];
    wire overflow_flag = interrupt_control_reg[`TIMER_COUNT_REG_INT_FLAG];
    wire overflow_irq_enable = interrupt_control_reg[`TIMER_COUNT_REG_INT_ENABLE];
    wire global_irq_enable = interrupt_control_reg[`TIMER_COUNT_REG_INT_GLOBAL];
    wire cycle_end = (phase_reg == 2'h3);

    assign pullup_disable_o = option_reg[`TIMER_COUNT_REG_OPT_PULLUP_OFF];
    assign int_rising_edge_o = option_reg[`TIMER_COUNT_REG_OPT_INT_EDGE];
    assign sleep_o = sleep_reg;
    assign overflow_irq_o = overflow_flag & overflow_irq_enable & global_irq_enable;

    // ----------------------------------------------------------------
    // phase clock and external input sampling
    // ----------------------------------------------------------------
    // phase 1 and 3 stand for the second and fourth quarter of the cycle
    wire sample_phase = phase_reg[0];
    // edge select by xor: falling edges become rising edges of the sampled level
    wire ext_pol = ext_count_i ^ option_reg[`TIMER_COUNT_REG_OPT_EDGE_SEL];

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_reg <= 2'h0;
            // idle-low pin xor reset edge select is high: start there, no false edge
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            ext_samp_reg <= 1'b1;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            sync1_reg <= ext_pol;
            sync2_reg <= sync1_reg;
            if (sample_phase) begin
                ext_samp_reg <= sync2_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // divider input: timer events or watchdog ticks
    // ----------------------------------------------------------------
    // one cycle pulse per qualifying edge, delayed by the synchroniser
    reg ext_samp_d_reg;
    wire ext_edge = ext_samp_reg & ~ext_samp_d_reg;
    wire timer_src_evt = src_ext ? ext_edge : cycle_end;
    wire running = ~sleep_reg & (inhibit_reg == 2'h0);
    wire div_in = to_wdt ? wdt_tick_i : (timer_src_evt & running);
    // divider clears on count write (timer owned) or watchdog clear (watchdog owned)
    wire div_clear = (~to_wdt & count_wr) | (to_wdt & wdt_clr_cmd);

    // bit ratio of the divider falls every 2^(ratio+1) input events
    wire [DIV_WIDTH-1:0] div_plus = div_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    wire tap_now = tap_bit(div_reg, ratio);
    wire tap_next = tap_bit(div_plus, ratio);
    wire timer_div_evt = div_in & tap_now & ~tap_next;
    wire wdt_lower_now = (ratio == 3'h0) ? 1'b1 : tap_bit(div_reg, ratio - 3'h1);
    wire wdt_lower_next = (ratio == 3'h0) ? 1'b0 : tap_bit(div_plus, ratio - 3'h1);
    // watchdog ratio 0 passes each tick undivided
    wire wdt_div_evt = div_in & wdt_lower_now & ~wdt_lower_next;
    // divider given to the watchdog leaves the timer undivided
    wire timer_inc = to_wdt ? (timer_src_evt & running) : timer_div_evt;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_reg <= {DIV_WIDTH{1'b0}};
            ext_samp_d_reg <= 1'b1;
            wdt_tick_o <= 1'b0;
            wdt_clear_o <= 1'b0;
        end else begin
            ext_samp_d_reg <= ext_samp_reg;
            // reassignment needs no stop; divider simply keeps running for the new owner
            if (div_clear) begin
                div_reg <= {DIV_WIDTH{1'b0}};
            end else if (div_in) begin
                div_reg <= div_plus;
            end
            wdt_tick_o <= to_wdt ? wdt_div_evt : wdt_tick_i;
            wdt_clear_o <= wdt_clr_cmd;
        end
    end

    // ----------------------------------------------------------------
    // count, inhibit, overflow flag, option, sleep
    // ----------------------------------------------------------------
    wire intctl_wr = apb_write & hit_intctl;
    wire overflow_set = timer_inc & (timer_count_reg == 8'hff);

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_count_reg <= 8'h00;
            option_reg <= `TIMER_COUNT_REG_OPT_RESET;
            interrupt_control_reg <= `TIMER_COUNT_REG_INT_RESET;
            sleep_reg <= 1'b0;
            inhibit_reg <= 2'h0;
        end else begin
            if (count_wr) begin
                timer_count_reg <= pwdata_i[7:0];
                inhibit_reg <= `TIMER_COUNT_REG_INHIBIT_CYC;
            end else begin
                if (timer_inc) begin
                    timer_count_reg <= timer_count_reg + 8'h01;
                end
                if (cycle_end && inhibit_reg != 2'h0) begin
                    inhibit_reg <= inhibit_reg - 2'h1;
                end
            end
            if (apb_write && hit_option) begin
                option_reg <= pwdata_i[7:0];
            end
            // flag set wins over a software clear in the same cycle
            if (intctl_wr) begin
                interrupt_control_reg <= pwdata_i[7:0] | {5'h00, overflow_set, 2'h0};
            end else if (overflow_set) begin
                interrupt_control_reg[`TIMER_COUNT_REG_INT_FLAG] <= 1'b1;
            end
            // sleep ends only by software clear here; wake logic lives elsewhere
            if (cmd_wr) begin
                sleep_reg <= pwdata_i[`TIMER_COUNT_REG_CMD_SLEEP];
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux; divider has no window at all
    // ----------------------------------------------------------------
    always @* begin
        prdata_o = 32'h00000000;
        if (apb_read) begin
            case (paddr_i)
                `TIMER_COUNT_REG_COUNT_OFS: prdata_o = {24'h000000, timer_count_reg};
                `TIMER_COUNT_REG_OPTION_OFS: prdata_o = {24'h000000, option_reg};
                `TIMER_COUNT_REG_INTCTL_OFS: prdata_o = {24'h000000, interrupt_control_reg};
                `TIMER_COUNT_REG_CMD_OFS: prdata_o = {30'h00000000, sleep_reg, 1'b0};
                default: prdata_o = 32'h00000000;
            endcase
        end
    end

endmodule // timer_count_reg_prescaler

// ---- testbench/timer_count_reg_chk.sv ----
// checker for the timer/divider block, bound to its ports
// assumes zero-wait apb slave and the register map of timer_count_reg_regs.vh
`timescale 1ns/10ps
`include "timer_count_reg_regs.vh"
module timer_count_reg_chk (
    input logic clk_i, reset_i, psel_i, penable_i, pwrite_i,
    input logic [11:0] paddr_i,
    input logic [31:0] pwdata_i, prdata_o,
    input logic pready_o, pslverr_o, ext_count_i, wdt_tick_i, wdt_tick_o,
    input logic wdt_clear_o, overflow_irq_o, pullup_disable_o, int_rising_edge_o, sleep_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic wr;
    logic [7:0] opt_q, ic_q;
    assign wr = psel_i & penable_i & pwrite_i;
    // shadow copies, so masks can be judged at the ports
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            opt_q <= 8'hff;
            ic_q <= 8'h00;
        end else if (wr && paddr_i == `TIMER_COUNT_REG_OPTION_OFS) begin
            opt_q <= pwdata_i[7:0];
        end else if (wr && paddr_i == `TIMER_COUNT_REG_INTCTL_OFS) begin
            ic_q <= pwdata_i[7:0];
        end
    end
    clr_pulse_a: assert property (wr && paddr_i == `TIMER_COUNT_REG_CMD_OFS && pwdata_i[0] |=> wdt_clear_o)
        else $error("watchdog clear pulse missing");
    clr_cause_a: assert property (wdt_clear_o |-> $past(wr && paddr_i == `TIMER_COUNT_REG_CMD_OFS && pwdata_i[0]))
        else $error("watchdog clear without command");
    opt_out_a: assert property (wr && paddr_i == `TIMER_COUNT_REG_OPTION_OFS |=>
        pullup_disable_o == $past(pwdata_i[7]) && int_rising_edge_o == $past(pwdata_i[6]))
        else $error("option outputs wrong");
    sleep_lvl_a: assert property (wr && paddr_i == `TIMER_COUNT_REG_CMD_OFS |=> sleep_o == $past(pwdata_i[1]))
        else $error("sleep level wrong");
    tick_pass_a: assert property (!opt_q[3] |=> wdt_tick_o == $past(wdt_tick_i))
        else $error("tick not passed undivided");
    tick_one_a: assert property (opt_q[3] && opt_q[2:0] == 3'h0 |=> wdt_tick_o == $past(wdt_tick_i))
        else $error("one to one tick wrong");
    unmapped_a: assert property (psel_i && penable_i && paddr_i > `TIMER_COUNT_REG_CMD_OFS |-> pslverr_o && prdata_o == 0)
        else $error("unmapped access not refused");
    irq_mask_a: assert property (!ic_q[5] |-> !overflow_irq_o)
        else $error("masked interrupt raised");
    sleep_irq_a: assert property (sleep_o && !overflow_irq_o && !wr |=> !overflow_irq_o)
        else $error("overflow during sleep");
    cover property (wdt_clear_o);
    cover property ($rose(overflow_irq_o));
    cover property (wr && paddr_i == `TIMER_COUNT_REG_OPTION_OFS);
endmodule // timer_count_reg_chk
bind timer_count_reg_prescaler timer_count_reg_chk u_chk (.*);

// ---- testbench/timer_count_reg_ext_src.sv ----
// external count source model driving the count pin
// assumes the caller starts each step just after a clock edge
`timescale 1ns/10ps
module timer_count_reg_ext_src (
    input logic clk_i,
    output logic ext_o
);
    initial ext_o = 1'b0;
    // each level held several clocks, so phase sampling sees it
    task step(input logic v, input int half);
        @(posedge clk_i);
        ext_o <= v;
        repeat (half) @(posedge clk_i);
    endtask
endmodule // timer_count_reg_ext_src

// ---- testbench/testbench.sv ----
// self-checking bench for the timer/divider block
// assumes timer_count_reg_regs.vh on the include path and the checker bound
`timescale 1ns/10ps
`include "timer_count_reg_regs.vh"
module testbench;
    logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, wdt_tick_i = 0, err_seen;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, r;
    logic pready_o, pslverr_o, ext_count_i, wdt_tick_o, wdt_clear_o, overflow_irq_o;
    logic pullup_disable_o, int_rising_edge_o, sleep_o;
    int miscompares = 0, tests_run = 0, cyc = 0, ticks = 0, n, t0;
    logic [11:0] ra[5] = '{12'h004, 12'h004, 12'h000, 12'h008, 12'h010};
    logic [31:0] rw[5] = '{32'hc3, 32'h37, 32'h5a, 32'h20, 32'hff};
    logic [31:0] re[5] = '{32'hc3, 32'h37, 32'h5a, 32'h20, 32'h00};
    always #10 clk_i = ~clk_i;
    timer_count_reg_prescaler DUT (.*);
    timer_count_reg_ext_src src (.clk_i(clk_i), .ext_o(ext_count_i));
    always @(posedge clk_i) begin
        cyc++;
        if (wdt_tick_o === 1'b1) ticks++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        err_seen = pslverr_o;
        psel_i <= 0; penable_i <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0); check(r, e); endtask
    // count write, then let the two-cycle inhibit run out
    task setcnt; wr(`TIMER_COUNT_REG_COUNT_OFS, 0); repeat (12) @(posedge clk_i); endtask
    task pulse(input int k); repeat (k) begin src.step(1, 4); src.step(0, 4); end endtask
    task tick(input int k);
        repeat (k) begin
            @(posedge clk_i) wdt_tick_i <= 1;
            @(posedge clk_i) wdt_tick_i <= 0;
        end
        repeat (3) @(posedge clk_i);
    endtask
    task wclr; wr(`TIMER_COUNT_REG_CMD_OFS, 1); endtask
    task done(input string s); $display("test done: %s", s); endtask
    task wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 0;
        rd(`TIMER_COUNT_REG_OPTION_OFS, 32'hff);
        rd(`TIMER_COUNT_REG_INTCTL_OFS, 0); rd(`TIMER_COUNT_REG_COUNT_OFS, 0); done("reset");
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], re[i]);
        end
        check(err_seen, 1); done("rows");
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h28); setcnt; src.step(1, 8); rd(0, 1);
        src.step(0, 8); rd(0, 1);
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h38); setcnt; src.step(1, 8); rd(0, 0);
        src.step(0, 8); rd(0, 1); done("edges");
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h20); setcnt; pulse(1); rd(0, 0);
        setcnt; pulse(1); rd(0, 0); pulse(1); rd(0, 1);
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h37); setcnt; pulse(256); rd(0, 1); done("divider");
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h08); wr(`TIMER_COUNT_REG_INTCTL_OFS, 32'ha0); wr(0, 32'hfe);
        n = 0;
        while (overflow_irq_o !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        check(n >= 12 && n <= 20, 1); rd(`TIMER_COUNT_REG_INTCTL_OFS, 32'ha4);
        wr(`TIMER_COUNT_REG_INTCTL_OFS, 32'h84); rd(`TIMER_COUNT_REG_INTCTL_OFS, 32'h84); check(overflow_irq_o, 0);
        wr(`TIMER_COUNT_REG_INTCTL_OFS, 32'h80); rd(`TIMER_COUNT_REG_INTCTL_OFS, 32'h80); done("overflow");
        wr(`TIMER_COUNT_REG_INTCTL_OFS, 32'ha0); wr(`TIMER_COUNT_REG_CMD_OFS, 2); wr(0, 32'hfe);
        repeat (40) @(posedge clk_i);
        rd(0, 32'hfe); check(overflow_irq_o, 0); check(sleep_o, 1);
        wr(`TIMER_COUNT_REG_CMD_OFS, 0); done("sleep");
        wclr; wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h01); t0 = ticks; tick(2); check(ticks - t0, 2);
        wr(0, 0); wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h09); t0 = ticks;
        wclr; tick(1); wclr; tick(2); check(ticks - t0, 1);
        wr(`TIMER_COUNT_REG_OPTION_OFS, 32'h08); t0 = ticks; tick(2); check(ticks - t0, 2); done("watchdog");
        // mid-run reset: registers back to reset values, no false count edge after it
        wr(0, 32'h33); @(posedge clk_i) reset_i <= 1;
        repeat (2) @(posedge clk_i);
        reset_i <= 0;
        rd(`TIMER_COUNT_REG_OPTION_OFS, 32'hff); rd(`TIMER_COUNT_REG_INTCTL_OFS, 0);
        repeat (12) @(posedge clk_i);
        rd(`TIMER_COUNT_REG_COUNT_OFS, 0); check(sleep_o, 0); done("reset again");
        wrap_up;
    end
endmodule // testbench
